// [dtp_defines.svh]
// Constants for the dual interval timer pair
`ifndef DTP_DEFINES_SVH
`define DTP_DEFINES_SVH

`define DTP_ADDR_W 8
`define DTP_DATA_W 8
`define DTP_ADDR_TA 8'hEB
`define DTP_ADDR_TB 8'hEC
`define DTP_CTL_RESET 8'h00

`define DTP_BIT_MODE 7
`define DTP_SEL_HI 6
`define DTP_SEL_LO 4
`define DTP_BIT_CLR 3
`define DTP_BIT_EN 2
`define DTP_BIT_IE 1
`define DTP_BIT_PND 0

`define DTP_DIV512_BITS 9
`define DTP_DIV256_BITS 8
`define DTP_DIV64_BITS 6
`define DTP_DIV8_BITS 3
`define DTP_TICK_W 7

`endif

// [dtp_pkg.sv]
// Types shared by the dual interval timer pair
package dtp_pkg;

  typedef enum logic [2:0] {
    DTP_SEL_DIV512 = 3'h0,
    DTP_SEL_DIV256 = 3'h1,
    DTP_SEL_DIV64 = 3'h2,
    DTP_SEL_DIV8 = 3'h3,
    DTP_SEL_DIV1 = 3'h4,
    DTP_SEL_SUB = 3'h5,
    DTP_SEL_EXT = 3'h6,
    DTP_SEL_NONE = 3'h7
  } dtp_clk_sel_t;

endpackage : dtp_pkg

// [dtp_prescaler.sv]
// Count clock prescaler and edge detect for the timer pair
`timescale 1ns/100ps
`include "dtp_defines.svh"

module dtp_prescaler
  import dtp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic subClk,
  input wire logic extClk,
  output logic [`DTP_TICK_W-1:0] tickVec
);

  logic [`DTP_DIV512_BITS-1:0] preCnt_ff;
  logic subPrev_ff;
  logic extPrev_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      preCnt_ff <= '0;
    end else begin
      preCnt_ff <= preCnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      subPrev_ff <= 1'b0;
      extPrev_ff <= 1'b0;
    end else begin
      subPrev_ff <= subClk;
      extPrev_ff <= extClk;
    end
  end

  // One enable pulse per divided period, indexed by the select code
  always_comb begin
    tickVec = '0;
    tickVec[DTP_SEL_DIV512] = &preCnt_ff[`DTP_DIV512_BITS-1:0];
    tickVec[DTP_SEL_DIV256] = &preCnt_ff[`DTP_DIV256_BITS-1:0];
    tickVec[DTP_SEL_DIV64] = &preCnt_ff[`DTP_DIV64_BITS-1:0];
    tickVec[DTP_SEL_DIV8] = &preCnt_ff[`DTP_DIV8_BITS-1:0];
    tickVec[DTP_SEL_DIV1] = 1'b1;
    tickVec[DTP_SEL_SUB] = subClk & ~subPrev_ff;
    tickVec[DTP_SEL_EXT] = extClk & ~extPrev_ff;
  end

endmodule : dtp_prescaler

// [dtp_timer.sv]
// Dual 8-bit / single 16-bit interval timer pair
// Overview of operation
// R01: Mode bit set chains both counters into one 16-bit timer, else two.
// R02: Timer A and 16-bit clocks: fxx/512,/256,/64,/8,/1, sub or external.
// R03: Timer B in 8-bit mode: fxx/512,/256,/64,/8 or sub clock only.
// R04: 16-bit compare uses A reference as upper byte, B as lower.
// R05: 16-bit match requests combined interrupt, clears counter, keeps counting.
// R06: 8-bit match per timer requests own interrupt and clears own counter.
// R07: Reset puts timer A control at zero: stopped, /512, no interrupt.
// R08: Reset puts timer B control at zero: stopped, /512, no interrupt.
// R09: Writing one to A clear bit clears A or combined counter.
// R10: Writing one to B clear bit clears B counter in 8-bit mode.
// R11: Software sets mode, enable and interrupt enable for 16-bit interrupts.
// R12: Software clears mode, sets enable and interrupt enable per timer.
// R13: Pending bit sets on match even with interrupt disabled; readable.
// R14: Pending bit stays until software writes zero to it.
// R15: Software writes clear one, pending zero together before starting.
// R16: In 8-bit mode each timer drives its own match output pin.
// R17: Each match output toggles on every match and starts low.
// R18: Counter advances per selected tick while enabled, holds when disabled.
`timescale 1ns/100ps
`include "dtp_defines.svh"

module dtp_timer
  import dtp_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [`DTP_ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [`DTP_DATA_W-1:0] regWrData,
  output logic [`DTP_DATA_W-1:0] regRdData,
  input wire logic [CNT_W-1:0] timerAReference,
  input wire logic [CNT_W-1:0] timerBReference,
  output logic [CNT_W-1:0] timerACount,
  output logic [CNT_W-1:0] timerBCount,
  input wire logic subClk,
  input wire logic externalCountClock,
  output logic combinedMatchIrq,
  output logic lowTimerAMatchIrq,
  output logic lowTimerBMatchIrq,
  output logic firstMatchOutput,
  output logic secondMatchOutput
);

  function automatic logic selTick(input logic [2:0] sel,
                                   input logic [`DTP_TICK_W-1:0] vec,
                                   input logic isTimerB);
    logic ok;
    logic [`DTP_TICK_W:0] ext;
    ok = 1'b1;
    // Pad so that the stopped code never indexes past the tick vector
    ext = {1'h0, vec};
    if (isTimerB && (sel == DTP_SEL_DIV1 || sel == DTP_SEL_EXT)) begin
      ok = 1'b0;
    end
    if (sel == DTP_SEL_NONE) begin
      ok = 1'b0;
    end
    selTick = ok && ext[sel];
  endfunction : selTick

  logic [`DTP_TICK_W-1:0] tickVec;
  logic [`DTP_DATA_W-1:0] taCtl_ff;
  logic [`DTP_DATA_W-1:0] tbCtl_ff;
  logic pendA_ff;
  logic pendB_ff;
  logic [CNT_W-1:0] cntA_ff;
  logic [CNT_W-1:0] cntB_ff;
  logic [CNT_W-1:0] nxt_cntA;
  logic [CNT_W-1:0] nxt_cntB;
  logic outA_ff;
  logic outB_ff;
  logic [`DTP_DATA_W-1:0] rdData_ff;
  logic wrA;
  logic wrB;
  logic mode16;
  logic tickA;
  logic tickB;
  logic runA;
  logic runB;
  logic clearA;
  logic clearB;
  logic match16;
  logic matchA;
  logic matchB;
  logic setPendA;
  logic [2*CNT_W-1:0] cnt16;
  logic [2*CNT_W-1:0] ref16;
  logic [2*CNT_W-1:0] inc16;

  dtp_prescaler dtp_prescaler_inst (
    .clk(clk),
    .rst(rst),
    .subClk(subClk),
    .extClk(externalCountClock),
    .tickVec(tickVec)
  );

  assign wrA = regWrEn && (regAddr == `DTP_ADDR_TA);
  assign wrB = regWrEn && (regAddr == `DTP_ADDR_TB);
  assign mode16 = taCtl_ff[`DTP_BIT_MODE]; // R01

  assign tickA = selTick(taCtl_ff[`DTP_SEL_HI:`DTP_SEL_LO], tickVec,
                         1'b0); // R02
  assign tickB = selTick(tbCtl_ff[`DTP_SEL_HI:`DTP_SEL_LO], tickVec,
                         1'b1); // R03
  assign runA = taCtl_ff[`DTP_BIT_EN] && tickA; // R18
  assign runB = !mode16 && tbCtl_ff[`DTP_BIT_EN] && tickB; // R18

  assign clearA = wrA && regWrData[`DTP_BIT_CLR]; // R09
  // In 16-bit mode only the A clear bit acts, on both halves; a write
  // that enters 16-bit mode with clear set also clears the low half
  assign clearB = (clearA && (mode16 || regWrData[`DTP_BIT_MODE])) ||
                  (!mode16 && wrB && regWrData[`DTP_BIT_CLR]); // R10

  assign cnt16 = {cntA_ff, cntB_ff};
  assign ref16 = {timerAReference, timerBReference}; // R04
  assign inc16 = cnt16 + 1'b1;
  assign match16 = mode16 && runA && (cnt16 == ref16); // R04
  assign matchA = !mode16 && runA && (cntA_ff == timerAReference); // R06
  assign matchB = runB && (cntB_ff == timerBReference); // R06
  assign setPendA = mode16 ? match16 : matchA; // R05

  always_comb begin
    nxt_cntA = cntA_ff;
    nxt_cntB = cntB_ff;
    if (mode16) begin
      if (match16) begin
        nxt_cntA = '0; // R05
        nxt_cntB = '0;
      end else if (runA) begin
        nxt_cntA = inc16[2*CNT_W-1:CNT_W]; // R01
        nxt_cntB = inc16[CNT_W-1:0];
      end
    end else begin
      if (matchA) begin
        nxt_cntA = '0; // R06
      end else if (runA) begin
        nxt_cntA = cntA_ff + 1'b1; // R18
      end
      if (matchB) begin
        nxt_cntB = '0; // R06
      end else if (runB) begin
        nxt_cntB = cntB_ff + 1'b1; // R18
      end
    end
  end

  // Counters: a software clear wins over counting
  always_ff @(posedge clk) begin
    if (rst) begin
      cntA_ff <= '0;
    end else if (clearA) begin
      cntA_ff <= '0; // R09
    end else begin
      cntA_ff <= nxt_cntA;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cntB_ff <= '0;
    end else if (clearB) begin
      cntB_ff <= '0; // R10
    end else begin
      cntB_ff <= nxt_cntB;
    end
  end

  // Control bits; the clear bit is a strobe and is never stored
  always_ff @(posedge clk) begin
    if (rst) begin
      taCtl_ff <= `DTP_CTL_RESET; // R07
    end else if (wrA) begin
      taCtl_ff <= {regWrData[`DTP_BIT_MODE:`DTP_SEL_LO], 1'b0,
                   regWrData[`DTP_BIT_EN:`DTP_BIT_IE], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tbCtl_ff <= `DTP_CTL_RESET; // R08
    end else if (wrB) begin
      tbCtl_ff <= {1'b0, regWrData[`DTP_SEL_HI:`DTP_SEL_LO], 1'b0,
                   regWrData[`DTP_BIT_EN:`DTP_BIT_IE], 1'b0};
    end
  end

  // Pending: match sets regardless of interrupt enable, only a written zero clears
  always_ff @(posedge clk) begin
    if (rst) begin
      pendA_ff <= 1'b0;
    end else if (setPendA) begin
      pendA_ff <= 1'b1; // R13
    end else if (wrA && !regWrData[`DTP_BIT_PND]) begin
      pendA_ff <= 1'b0; // R14
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pendB_ff <= 1'b0;
    end else if (matchB) begin
      pendB_ff <= 1'b1; // R13
    end else if (wrB && !regWrData[`DTP_BIT_PND]) begin
      pendB_ff <= 1'b0; // R14
    end
  end

  // Match outputs toggle in 8-bit mode only
  always_ff @(posedge clk) begin
    if (rst) begin
      outA_ff <= 1'b0;
      outB_ff <= 1'b0;
    end else begin
      if (matchA) begin
        outA_ff <= ~outA_ff; // R17
      end
      if (matchB) begin
        outB_ff <= ~outB_ff; // R17
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_ff <= '0;
    end else if (regAddr == `DTP_ADDR_TA) begin
      rdData_ff <= {taCtl_ff[`DTP_DATA_W-1:1], pendA_ff}; // R13
    end else if (regAddr == `DTP_ADDR_TB) begin
      rdData_ff <= {tbCtl_ff[`DTP_DATA_W-1:1], pendB_ff}; // R13
    end else begin
      rdData_ff <= '0;
    end
  end

  assign regRdData = rdData_ff;
  assign timerACount = cntA_ff;
  assign timerBCount = cntB_ff;
  assign firstMatchOutput = outA_ff; // R16
  assign secondMatchOutput = outB_ff; // R16
  // Interrupt requests are pending gated by enable, per mode
  assign combinedMatchIrq = mode16 && pendA_ff &&
                            taCtl_ff[`DTP_BIT_IE]; // R11
  assign lowTimerAMatchIrq = !mode16 && pendA_ff &&
                             taCtl_ff[`DTP_BIT_IE]; // R12
  assign lowTimerBMatchIrq = !mode16 && pendB_ff &&
                             tbCtl_ff[`DTP_BIT_IE]; // R12

  default clocking cb @(posedge clk);
  endclocking

  chk_reset_ctrl: assert property (rst |=> // R07
    (taCtl_ff == `DTP_CTL_RESET && tbCtl_ff == `DTP_CTL_RESET))
    else $error("control registers not cleared by reset");
  chk_chain_carry: assert property (disable iff (rst) // R01
    (mode16 && runA && !match16 && !clearA && cntB_ff == '1) |=>
    (cntB_ff == '0 && cntA_ff == $past(cntA_ff) + 1'b1))
    else $error("16-bit carry not passed to upper counter");
  chk_b_no_div1: assert property (disable iff (rst) // R03
    (!mode16 && !clearB && (tbCtl_ff[`DTP_SEL_HI:`DTP_SEL_LO] == DTP_SEL_DIV1 ||
     tbCtl_ff[`DTP_SEL_HI:`DTP_SEL_LO] == DTP_SEL_EXT)) |=> $stable(cntB_ff))
    else $error("timer B counted on a forbidden clock");
  chk_match16_clear: assert property (disable iff (rst) // R05
    (match16 && !clearA) |=> (cnt16 == '0 && pendA_ff))
    else $error("16-bit match did not clear counter and set pending");
  chk_match_a: assert property (disable iff (rst) // R06
    (matchA && !clearA) |=> (cntA_ff == '0 && pendA_ff))
    else $error("timer A match did not clear and set pending");
  chk_match_b: assert property (disable iff (rst) // R06
    (matchB && !clearB) |=> (cntB_ff == '0 && pendB_ff))
    else $error("timer B match did not clear and set pending");
  chk_clear_a: assert property (disable iff (rst) // R09
    clearA |=> cntA_ff == '0)
    else $error("timer A clear strobe ignored");
  chk_clear_b: assert property (disable iff (rst) // R10
    clearB |=> cntB_ff == '0)
    else $error("timer B clear strobe ignored");
  chk_pend_poll: assert property (disable iff (rst) // R13
    (matchB && !tbCtl_ff[`DTP_BIT_IE] && !wrB) |=>
    (pendB_ff && !lowTimerBMatchIrq))
    else $error("pending not set with interrupt disabled");
  chk_pend_hold: assert property (disable iff (rst) // R14
    (pendA_ff && !(wrA && !regWrData[`DTP_BIT_PND])) |=> pendA_ff)
    else $error("pending A dropped without a zero write");
  chk_out_toggle: assert property (disable iff (rst) // R17
    matchA |=> firstMatchOutput != $past(firstMatchOutput))
    else $error("match output A did not toggle");
  chk_count_hold: assert property (disable iff (rst) // R18
    (!taCtl_ff[`DTP_BIT_EN] && !clearA) |=> $stable(cntA_ff))
    else $error("timer A moved while disabled");
  chk_out_quiet: assert property (disable iff (rst) // R16
    (mode16 && !wrA) |=>
    ($stable(firstMatchOutput) && $stable(secondMatchOutput)))
    else $error("match output moved in 16-bit mode");

  cov_match16: cover property (disable iff (rst) match16);
  cov_match_both: cover property (disable iff (rst) matchA && matchB);
  cov_set_and_clear: cover property (disable iff (rst)
    matchB && wrB && !regWrData[`DTP_BIT_PND]);
  cov_poll_b: cover property (disable iff (rst)
    matchB && !tbCtl_ff[`DTP_BIT_IE]);

endmodule : dtp_timer

// [dtp_timer_tb_top.sv]
// Self-checking testbench for the dual interval timer pair
`timescale 1ns/100ps
`include "dtp_defines.svh"

module dtp_timer_tb_top
  import dtp_pkg::*;
  ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic regWrEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic [7:0] timerAReference = 8'h00;
  logic [7:0] timerBReference = 8'h00;
  logic [7:0] timerACount;
  logic [7:0] timerBCount;
  logic subClk = 1'b0;
  logic externalCountClock = 1'b0;
  logic combinedMatchIrq;
  logic lowTimerAMatchIrq;
  logic lowTimerBMatchIrq;
  logic firstMatchOutput;
  logic secondMatchOutput;
  int errCount = 0;
  int nChecks = 0;
  logic [15:0] prev;
  logic [7:0] rdv;

  always #20 clk = ~clk;

  dtp_timer dtp_timer_inst (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
    .timerAReference(timerAReference), .timerBReference(timerBReference),
    .timerACount(timerACount), .timerBCount(timerBCount), .subClk(subClk),
    .externalCountClock(externalCountClock),
    .combinedMatchIrq(combinedMatchIrq),
    .lowTimerAMatchIrq(lowTimerAMatchIrq),
    .lowTimerBMatchIrq(lowTimerBMatchIrq),
    .firstMatchOutput(firstMatchOutput),
    .secondMatchOutput(secondMatchOutput));

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask : chk

  task automatic endSim();
    if (errCount == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : endSim

  // Write is taken at the second edge; sample just after it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    repeat (2) @(posedge clk);
    #1;
    d = regRdData;
  endtask : rd

  // Returns the count seen in the cycle before the interrupt rose
  task automatic waitIrq(input int sel, input int lim,
                         output logic [15:0] p);
    logic hit;
    int n;
    hit = 1'b0;
    n = 0;
    p = {timerACount, timerBCount};
    while (!hit && n < lim) begin
      @(posedge clk);
      #1;
      case (sel)
        0: hit = (combinedMatchIrq === 1'b1);
        1: hit = (lowTimerAMatchIrq === 1'b1);
        default: hit = (lowTimerBMatchIrq === 1'b1);
      endcase
      if (!hit) p = {timerACount, timerBCount};
      n++;
    end
    chk("irq wait", 16'h0001, {15'h0000, hit});
  endtask : waitIrq

  task automatic pulse(input logic isExt, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (isExt) externalCountClock <= 1'b1;
      else subClk <= 1'b1;
      repeat (3) @(posedge clk);
      externalCountClock <= 1'b0;
      subClk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    #1;
  endtask : pulse

  task automatic tReset();
    rd(`DTP_ADDR_TA, rdv);
    chk("ctl A", 16'h0000, {8'h00, rdv});
    rd(`DTP_ADDR_TB, rdv);
    chk("ctl B", 16'h0000, {8'h00, rdv});
    rd(8'h10, rdv);
    chk("unmapped", 16'h0000, {8'h00, rdv});
    chk("outs", 16'h0000, {firstMatchOutput, secondMatchOutput});
  endtask : tReset

  task automatic tTimerA();
    timerAReference <= 8'h03;
    wr(`DTP_ADDR_TA, 8'h46);
    waitIrq(1, 20, prev);
    chk("A ref", 16'h0003, {8'h00, prev[15:8]});
    chk("A cnt", 16'h0000, {8'h00, timerACount});
    chk("A out", 16'h0001, {15'h0000, firstMatchOutput});
    chk("16 irq", 16'h0000, {combinedMatchIrq, lowTimerBMatchIrq});
    repeat (4) @(posedge clk);
    #1;
    chk("A out2", 16'h0000, {15'h0000, firstMatchOutput});
    rd(`DTP_ADDR_TA, rdv);
    chk("A pend", 16'h0047, {8'h00, rdv});
    wr(`DTP_ADDR_TA, 8'h43);
    wr(`DTP_ADDR_TA, 8'h42);
    chk("A irq", 16'h0000, {15'h0000, lowTimerAMatchIrq});
    prev[7:0] = timerACount;
    repeat (10) @(posedge clk);
    #1;
    chk("A hold", {8'h00, prev[7:0]}, {8'h00, timerACount});
    wr(`DTP_ADDR_TA, 8'h6E);
    chk("A clr", 16'h0000, {8'h00, timerACount});
    pulse(1'b1, 3);
    chk("A ext", 16'h0003, {8'h00, timerACount});
    wr(`DTP_ADDR_TA, 8'h00);
  endtask : tTimerA

  task automatic tTimerB();
    timerBReference <= 8'hFF;
    wr(`DTP_ADDR_TB, 8'h44);
    repeat (16) @(posedge clk);
    #1;
    chk("B div1", 16'h0000, {8'h00, timerBCount});
    wr(`DTP_ADDR_TB, 8'h64);
    pulse(1'b1, 2);
    chk("B ext", 16'h0000, {8'h00, timerBCount});
    timerBReference <= 8'h01;
    wr(`DTP_ADDR_TB, 8'h3E);
    waitIrq(2, 64, prev);
    chk("B ref", 16'h0001, {8'h00, prev[7:0]});
    chk("B out", 16'h0001, {15'h0000, secondMatchOutput});
    rd(`DTP_ADDR_TB, rdv);
    chk("B pend", 16'h0037, {8'h00, rdv});
    wr(`DTP_ADDR_TB, 8'h03);
    rd(`DTP_ADDR_TB, rdv);
    chk("B keep", 16'h0003, {8'h00, rdv});
    timerBReference <= 8'h02;
    wr(`DTP_ADDR_TB, 8'h5C);
    pulse(1'b0, 2);
    chk("B sub", 16'h0002, {8'h00, timerBCount});
    wr(`DTP_ADDR_TB, 8'h5C);
    chk("B clr", 16'h0000, {8'h00, timerBCount});
    pulse(1'b0, 3);
    rd(`DTP_ADDR_TB, rdv);
    chk("B poll", 16'h0055, {8'h00, rdv});
    chk("B irq off", 16'h0000, {15'h0000, lowTimerBMatchIrq});
    chk("B out2", 16'h0000, {15'h0000, secondMatchOutput});
    wr(`DTP_ADDR_TB, 8'h00);
  endtask : tTimerB

  // Slow dividers: a window of two divided periods holds exactly two ticks
  task automatic tDividers();
    timerAReference <= 8'hFF;
    timerBReference <= 8'hFF;
    wr(`DTP_ADDR_TA, 8'h2C);
    repeat (128) @(posedge clk);
    #1;
    chk("A div64", 16'h0002, {8'h00, timerACount});
    wr(`DTP_ADDR_TA, 8'h1C);
    repeat (512) @(posedge clk);
    #1;
    chk("A div256", 16'h0002, {8'h00, timerACount});
    wr(`DTP_ADDR_TA, 8'h00);
    wr(`DTP_ADDR_TB, 8'h0C);
    repeat (1024) @(posedge clk);
    #1;
    chk("B div512", 16'h0002, {8'h00, timerBCount});
    wr(`DTP_ADDR_TB, 8'h00);
  endtask : tDividers

  task automatic tSixteen();
    timerAReference <= 8'h01;
    timerBReference <= 8'h02;
    wr(`DTP_ADDR_TA, 8'hCE);
    chk("16 clr", 16'h0000, {timerACount, timerBCount});
    waitIrq(0, 400, prev);
    chk("16 ref", 16'h0102, prev);
    chk("16 cnt", 16'h0000, {timerACount, timerBCount});
    chk("8 irq", 16'h0000, {lowTimerAMatchIrq, lowTimerBMatchIrq});
    repeat (5) @(posedge clk);
    #1;
    chk("16 run", 16'h0005, {timerACount, timerBCount});
    wr(`DTP_ADDR_TA, 8'hCE);
    chk("16 clr2", 16'h0000, {timerACount, timerBCount});
    rd(`DTP_ADDR_TA, rdv);
    chk("16 pend", 16'h00C6, {8'h00, rdv});
    chk("16 irq off", 16'h0000, {15'h0000, combinedMatchIrq});
  endtask : tSixteen

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tReset();
    tTimerA();
    tTimerB();
    tDividers();
    tSixteen();
    endSim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    endSim();
  end
endmodule : dtp_timer_tb_top
